/* tmrocp_pkg.sv */
// constants of the timer output compare and one-pulse block
package tmrocp_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTL_ONE = 8'h00;
   localparam logic [7:0] ADDR_CTL_TWO = 8'h04;
   localparam logic [7:0] ADDR_FLAGS = 8'h08;
   localparam logic [7:0] ADDR_CMP1_HI = 8'h0c;
   localparam logic [7:0] ADDR_CMP1_LO = 8'h10;
   localparam logic [7:0] ADDR_CMP2_HI = 8'h14;
   localparam logic [7:0] ADDR_CMP2_LO = 8'h18;
   localparam logic [7:0] ADDR_CAP1_HI = 8'h1c;
   localparam logic [7:0] ADDR_CAP1_LO = 8'h20;
   localparam logic [7:0] ADDR_CAP2_HI = 8'h24;
   localparam logic [7:0] ADDR_CAP2_LO = 8'h28;
   localparam logic [7:0] ADDR_CNT_HI = 8'h2c;
   localparam logic [7:0] ADDR_CNT_LO = 8'h30;
   // ------------------------------------------------------------
   // field positions, timer_control_one
   // ------------------------------------------------------------
   localparam int C1_CAP_IRQ_EN = 0;
   localparam int C1_CMP_IRQ_EN = 1;
   localparam int C1_CAP1_EDGE = 2;
   localparam int C1_CAP2_EDGE = 3;
   localparam int C1_LEVEL1 = 4;
   localparam int C1_LEVEL2 = 5;
   localparam int C1_FORCE1 = 6;
   localparam int C1_FORCE2 = 7;
   // ------------------------------------------------------------
   // field positions, timer_control_two
   // ------------------------------------------------------------
   localparam int C2_PIN_EN1 = 0;
   localparam int C2_PIN_EN2 = 1;
   localparam int C2_ONE_PULSE = 2;
   localparam int C2_PWM = 3;
   localparam int C2_PRESC_LO = 4;
   localparam int C2_EXT_EDGE = 6;
   // ------------------------------------------------------------
   // flag positions, timer_flags_register
   // ------------------------------------------------------------
   localparam int F_CAP1 = 0;
   localparam int F_CAP2 = 1;
   localparam int F_CMP1 = 2;
   localparam int F_CMP2 = 3;
   // ------------------------------------------------------------
   // reset values and counts
   // ------------------------------------------------------------
   localparam logic [15:0] CMP_RESET = 16'h8000;
   localparam logic [15:0] CNT_RELOAD = 16'hfffc;
   localparam logic [7:0] CTL_ONE_RESET = 8'h00;
   localparam logic [7:0] CTL_TWO_RESET = 8'h00;
   localparam logic [1:0] PRESC_DIV2 = 2'h0;
   localparam logic [1:0] PRESC_DIV4 = 2'h1;
   localparam logic [1:0] PRESC_DIV8 = 2'h2;
   localparam logic [1:0] PRESC_EXT = 2'h3;
   localparam logic [2:0] DIV2_MASK = 3'h1;
   localparam logic [2:0] DIV4_MASK = 3'h3;
   localparam logic [2:0] DIV8_MASK = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* tmrocp_top.sv */
// output compare and one-pulse logic of a 16-bit timer, axi4-lite slave
`timescale 1ns/10ps
`default_nettype none
// How it works
// - two 16-bit compares checked every timer tick
// - compare registers software only, reset 8000h
// - match sets flag, drives level on pin
// - compare pin latches low during reset
// - irq needs enable set and mask clear
// - compare flag clears: status read, low access
// - high byte write inhibits compare until low
// - pin disabled: no level, irq still possible
// - flag and pin applied when counter equals
// - tick is clock/2, /4, /8 or external
// - force copies level to pin, no flag
// - force ignored in one-pulse or pwm
// - one-pulse select uses capture1 and compare1
// - trigger: capture, reload fffc, during level, flag
// - trigger flag requests irq when enabled
// - capture flag clears: status read, low access
// - compare1 equal in one-pulse: after level
// - one-pulse never sets compare flag one
// - pwm and one-pulse both set: pwm wins
// - one-pulse: capture two still works normally
// - one-pulse: channel two drives no pin
// - counter counts up, reloads only fffc
// - capture one edge from control one bit
module tmrocp_top (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // timer pins
   input wire logic capture_input_one_i,
   input wire logic capture_input_two_i,
   input wire logic ext_clk_i,
   output logic [1:0] compare_output_pin_o,
   output logic [1:0] compare_output_pin_oe_o,
   // interrupt
   input wire logic global_irq_mask_i,
   output logic timer_irq_o
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic aw_got_q, w_got_q;
   logic [7:0] aw_addr_q;
   logic [7:0] w_byte_q;
   logic w_lane_q;
   logic wr_fire;
   logic rd_fire;
   logic [7:0] ctl_one_q, ctl_two_q;
   logic [15:0] cmp1_q, cmp2_q, cap1_q, cap2_q, cnt_q, cnt_inc;
   logic [1:0] inhibit_q;
   logic [3:0] flag_q, arm_q, flag_set, flag_clr;
   logic [2:0] div_q, div_mask;
   logic [2:0] sync_q [3];
   logic [2:0] stab_q, rise, fall;
   logic tick, cnt_lo_wr, opm_sel, pwm_sel, opm_act;
   logic cap1_evt, cap2_evt, opm_trig, match1, match2;
   logic force1, force2;
   logic [1:0] pin_q;
   logic [31:0] rd_data;
   logic rd_ok;

   assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid_o;
   assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
   assign opm_sel = ctl_two_q[tmrocp_pkg::C2_ONE_PULSE];
   assign pwm_sel = ctl_two_q[tmrocp_pkg::C2_PWM];
   assign opm_act = opm_sel && !pwm_sel;
   assign cnt_lo_wr = wr_fire && w_lane_q && (aw_addr_q == tmrocp_pkg::ADDR_CNT_LO);

   // ------------------------------------------------------------
   // axi4-lite write channel
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         aw_got_q <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_got_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr_i;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
         aw_got_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         w_got_q <= 1'b0;
         w_byte_q <= 8'h00;
         w_lane_q <= 1'b0;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_got_q <= 1'b1;
         w_byte_q <= s_axi_wdata_i[7:0];
         w_lane_q <= s_axi_wstrb_i[0];
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
         w_got_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
      end else begin
         s_axi_awready_o <= !aw_got_q && !(s_axi_awvalid_i && s_axi_awready_o);
         s_axi_wready_o <= !w_got_q && !(s_axi_wvalid_i && s_axi_wready_o);
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= tmrocp_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o <= (aw_addr_q > tmrocp_pkg::ADDR_CNT_LO || aw_addr_q[1:0] != 2'h0)
                          ? tmrocp_pkg::RESP_SLVERR : tmrocp_pkg::RESP_OKAY;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // control registers; force bits are write-one pulses
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ctl_one_q <= tmrocp_pkg::CTL_ONE_RESET;
         ctl_two_q <= tmrocp_pkg::CTL_TWO_RESET;
         force1 <= 1'b0;
         force2 <= 1'b0;
      end else begin
         force1 <= 1'b0;
         force2 <= 1'b0;
         if (wr_fire && w_lane_q && aw_addr_q == tmrocp_pkg::ADDR_CTL_ONE) begin
            ctl_one_q <= {2'h0, w_byte_q[5:0]};
            force1 <= w_byte_q[tmrocp_pkg::C1_FORCE1];
            force2 <= w_byte_q[tmrocp_pkg::C1_FORCE2];
         end else if (wr_fire && w_lane_q && aw_addr_q == tmrocp_pkg::ADDR_CTL_TWO) begin
            ctl_two_q <= {1'b0, w_byte_q[6:0]};
         end
      end
   end

   // ------------------------------------------------------------
   // compare values and high-byte inhibit
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cmp1_q <= tmrocp_pkg::CMP_RESET;
         cmp2_q <= tmrocp_pkg::CMP_RESET;
         inhibit_q <= 2'h0;
      end else if (wr_fire && w_lane_q) begin
         if (aw_addr_q == tmrocp_pkg::ADDR_CMP1_HI) begin
            cmp1_q[15:8] <= w_byte_q;
            inhibit_q[0] <= 1'b1;
         end else if (aw_addr_q == tmrocp_pkg::ADDR_CMP1_LO) begin
            cmp1_q[7:0] <= w_byte_q;
            inhibit_q[0] <= 1'b0;
         end else if (aw_addr_q == tmrocp_pkg::ADDR_CMP2_HI) begin
            cmp2_q[15:8] <= w_byte_q;
            inhibit_q[1] <= 1'b1;
         end else if (aw_addr_q == tmrocp_pkg::ADDR_CMP2_LO) begin
            cmp2_q[7:0] <= w_byte_q;
            inhibit_q[1] <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // pin synchronisers: capture one, capture two, external clock
   // ------------------------------------------------------------
   for (genvar g = 0; g < 3; g++) begin : g_sync
      logic pin_in;
      assign pin_in = (g == 0) ? capture_input_one_i :
                      (g == 1) ? capture_input_two_i : ext_clk_i;
      always_ff @(posedge sys_clk_i or posedge reset_i) begin
         if (reset_i) begin
            sync_q[g] <= 3'h0;
            stab_q[g] <= 1'b0;
         end else begin
            sync_q[g] <= {sync_q[g][1:0], pin_in};
            if (sync_q[g][1] == sync_q[g][2]) begin
               stab_q[g] <= sync_q[g][2];
            end
         end
      end
      assign rise[g] = (sync_q[g][1] == sync_q[g][2]) && sync_q[g][2] && !stab_q[g];
      assign fall[g] = (sync_q[g][1] == sync_q[g][2]) && !sync_q[g][2] && stab_q[g];
   end

   // ------------------------------------------------------------
   // timer tick and counter
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         div_q <= 3'h0;
      end else begin
         div_q <= div_q + 3'h1;
      end
   end

   always_comb begin
      div_mask = tmrocp_pkg::DIV8_MASK;
      tick = 1'b0;
      if (ctl_two_q[5:4] == tmrocp_pkg::PRESC_DIV2) begin
         div_mask = tmrocp_pkg::DIV2_MASK;
      end else if (ctl_two_q[5:4] == tmrocp_pkg::PRESC_DIV4) begin
         div_mask = tmrocp_pkg::DIV4_MASK;
      end
      if (ctl_two_q[5:4] == tmrocp_pkg::PRESC_EXT) begin
         tick = ctl_two_q[tmrocp_pkg::C2_EXT_EDGE] ? rise[2] : fall[2];
      end else begin
         tick = ((div_q & div_mask) == div_mask);
      end
   end

   assign cnt_inc = cnt_q + 16'h0001;
   assign cap1_evt = (ctl_one_q[tmrocp_pkg::C1_CAP1_EDGE] ? rise[0] : fall[0])
                     && !pwm_sel;
   assign cap2_evt = ctl_one_q[tmrocp_pkg::C1_CAP2_EDGE] ? rise[1] : fall[1];
   assign opm_trig = cap1_evt && opm_act;

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q <= tmrocp_pkg::CNT_RELOAD;
      end else if (cnt_lo_wr || opm_trig) begin
         cnt_q <= tmrocp_pkg::CNT_RELOAD;
      end else if (tick) begin
         cnt_q <= cnt_inc;
      end
   end

   // match marks the edge at which the counter becomes equal
   assign match1 = tick && !cnt_lo_wr && !opm_trig && !inhibit_q[0]
                   && (cnt_inc == cmp1_q);
   assign match2 = tick && !cnt_lo_wr && !opm_trig && !inhibit_q[1]
                   && (cnt_inc == cmp2_q);

   // ------------------------------------------------------------
   // capture registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cap1_q <= 16'h0000;
         cap2_q <= 16'h0000;
      end else begin
         if (cap1_evt) begin
            cap1_q <= cnt_q;
         end
         if (cap2_evt) begin
            cap2_q <= cnt_q;
         end
      end
   end

   // ------------------------------------------------------------
   // flags: set wins over clear
   // ------------------------------------------------------------
   assign flag_set[tmrocp_pkg::F_CAP1] = cap1_evt;
   assign flag_set[tmrocp_pkg::F_CAP2] = cap2_evt;
   assign flag_set[tmrocp_pkg::F_CMP1] = match1 && !opm_sel && !pwm_sel;
   assign flag_set[tmrocp_pkg::F_CMP2] = match2 && !pwm_sel;

   // low-byte access by read or write, after the status read armed it
   always_comb begin
      flag_clr = 4'h0;
      if (wr_fire && w_lane_q) begin
         flag_clr[tmrocp_pkg::F_CMP1] = aw_addr_q == tmrocp_pkg::ADDR_CMP1_LO;
         flag_clr[tmrocp_pkg::F_CMP2] = aw_addr_q == tmrocp_pkg::ADDR_CMP2_LO;
         flag_clr[tmrocp_pkg::F_CAP1] = aw_addr_q == tmrocp_pkg::ADDR_CAP1_LO;
         flag_clr[tmrocp_pkg::F_CAP2] = aw_addr_q == tmrocp_pkg::ADDR_CAP2_LO;
      end
      if (rd_fire) begin
         flag_clr[tmrocp_pkg::F_CMP1] |= s_axi_araddr_i == tmrocp_pkg::ADDR_CMP1_LO;
         flag_clr[tmrocp_pkg::F_CMP2] |= s_axi_araddr_i == tmrocp_pkg::ADDR_CMP2_LO;
         flag_clr[tmrocp_pkg::F_CAP1] |= s_axi_araddr_i == tmrocp_pkg::ADDR_CAP1_LO;
         flag_clr[tmrocp_pkg::F_CAP2] |= s_axi_araddr_i == tmrocp_pkg::ADDR_CAP2_LO;
      end
      flag_clr = flag_clr & arm_q;
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         flag_q <= 4'h0;
         arm_q <= 4'h0;
      end else begin
         flag_q <= flag_set | (flag_q & ~flag_clr);
         if (rd_fire && s_axi_araddr_i == tmrocp_pkg::ADDR_FLAGS) begin
            arm_q <= (arm_q & ~flag_clr) | flag_q;
         end else begin
            arm_q <= arm_q & ~flag_clr;
         end
      end
   end

   // ------------------------------------------------------------
   // compare pin latches
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pin_q <= 2'h0;
      end else begin
         if (ctl_two_q[tmrocp_pkg::C2_PIN_EN1]) begin
            if (opm_trig) begin
               pin_q[0] <= ctl_one_q[tmrocp_pkg::C1_LEVEL2];
            end else if (match1) begin
               pin_q[0] <= ctl_one_q[tmrocp_pkg::C1_LEVEL1];
            end else if (force1 && !opm_sel && !pwm_sel) begin
               pin_q[0] <= ctl_one_q[tmrocp_pkg::C1_LEVEL1];
            end
         end
         if (ctl_two_q[tmrocp_pkg::C2_PIN_EN2] && !opm_act) begin
            if (match2) begin
               pin_q[1] <= ctl_one_q[tmrocp_pkg::C1_LEVEL2];
            end else if (force2 && !opm_sel && !pwm_sel) begin
               pin_q[1] <= ctl_one_q[tmrocp_pkg::C1_LEVEL2];
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         compare_output_pin_o <= 2'h0;
         compare_output_pin_oe_o <= 2'h0;
      end else begin
         compare_output_pin_o <= pin_q;
         compare_output_pin_oe_o <= {ctl_two_q[tmrocp_pkg::C2_PIN_EN2] && !opm_act,
                                     ctl_two_q[tmrocp_pkg::C2_PIN_EN1]};
      end
   end

   // ------------------------------------------------------------
   // interrupt request
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         timer_irq_o <= 1'b0;
      end else begin
         timer_irq_o <= !global_irq_mask_i &&
            ((ctl_one_q[tmrocp_pkg::C1_CMP_IRQ_EN] && (flag_q[2] || flag_q[3])) ||
             (ctl_one_q[tmrocp_pkg::C1_CAP_IRQ_EN] && (flag_q[0] || flag_q[1])));
      end
   end

   // ------------------------------------------------------------
   // axi4-lite read channel
   // ------------------------------------------------------------
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_ok = 1'b1;
      if (s_axi_araddr_i == tmrocp_pkg::ADDR_CTL_ONE) begin
         rd_data[7:0] = ctl_one_q;
      end else if (s_axi_araddr_i == tmrocp_pkg::ADDR_CTL_TWO) begin
         rd_data[7:0] = ctl_two_q;
      end else if (s_axi_araddr_i == tmrocp_pkg::ADDR_FLAGS) begin
         rd_data[3:0] = flag_q;
      end else if (s_axi_araddr_i == tmrocp_pkg::ADDR_CMP1_HI) begin
         rd_data[7:0] = cmp1_q[15:8];
      end else if (s_axi_araddr_i == tmrocp_pkg::ADDR_CMP1_LO) begin
         rd_data[7:0] = cmp1_q[7:0];
      end else if (s_axi_araddr_i == tmrocp_pkg::ADDR_CMP2_HI) begin
         rd_data[7:0] = cmp2_q[15:8];
      end else if (s_axi_araddr_i == tmrocp_pkg::ADDR_CMP2_LO) begin
         rd_data[7:0] = cmp2_q[7:0];
      end else if (s_axi_araddr_i == tmrocp_pkg::ADDR_CAP1_HI) begin
         rd_data[7:0] = cap1_q[15:8];
      end else if (s_axi_araddr_i == tmrocp_pkg::ADDR_CAP1_LO) begin
         rd_data[7:0] = cap1_q[7:0];
      end else if (s_axi_araddr_i == tmrocp_pkg::ADDR_CAP2_HI) begin
         rd_data[7:0] = cap2_q[15:8];
      end else if (s_axi_araddr_i == tmrocp_pkg::ADDR_CAP2_LO) begin
         rd_data[7:0] = cap2_q[7:0];
      end else if (s_axi_araddr_i == tmrocp_pkg::ADDR_CNT_HI) begin
         rd_data[7:0] = cnt_q[15:8];
      end else if (s_axi_araddr_i == tmrocp_pkg::ADDR_CNT_LO) begin
         rd_data[7:0] = cnt_q[7:0];
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= tmrocp_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rd_data;
         s_axi_rresp_o <= rd_ok ? tmrocp_pkg::RESP_OKAY : tmrocp_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_o) begin
         if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
         end
      end else begin
         s_axi_arready_o <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   a_cmp_sw_only: assert property ($changed(cmp1_q) |-> $past(wr_fire))
      else $error("compare one changed without a bus write");
   a_flag_on_match: assert property (match2 && !pwm_sel |=> flag_q[3])
      else $error("compare two flag not set on match");
   a_irq_masked: assert property (global_irq_mask_i |=> !timer_irq_o)
      else $error("irq raised while globally masked");
   a_irq_cmp_gate: assert property (!global_irq_mask_i && flag_q[2]
      && ctl_one_q[1] |=> timer_irq_o)
      else $error("enabled compare flag gave no irq");
   a_flag_clear_armed: assert property ($fell(flag_q[2]) |-> $past(arm_q[2]))
      else $error("compare flag cleared without status read");
   a_inhibit_blocks: assert property (inhibit_q[0] |=> !$rose(flag_q[tmrocp_pkg::F_CMP1]))
      else $error("match while high byte inhibit held");
   a_opm_flag_one: assert property (opm_sel |=> !$rose(flag_q[2]))
      else $error("compare flag one set in one-pulse mode");
   a_opm_trigger: assert property (opm_trig && ctl_two_q[0] |=> cnt_q == 16'hfffc
      && pin_q[0] == $past(ctl_one_q[5]) && flag_q[0])
      else $error("one-pulse trigger effects missing");
   a_pin_level: assert property (match1 && ctl_two_q[0] && !opm_trig
      |=> ##1 compare_output_pin_o[0] == $past(ctl_one_q[4], 2))
      else $error("pin did not take compare level");
   a_div2_tick: assert property (ctl_two_q[5:4] == 2'h0 && tick
      |=> !tick ##1 (tick || ctl_two_q[5:4] != 2'h0))
      else $error("divide by two tick spacing wrong");

   c_match_one: cover property (match1 && ctl_two_q[0]);
   c_opm_pulse: cover property (opm_trig ##[1:1000] match1);
   c_flag_clear: cover property ($fell(flag_q[3]));
   c_force: cover property (force1 && ctl_two_q[0]);

endmodule // tmrocp_top
`default_nettype wire

/* tmrocp_partner.sv */
// trigger source and waveform load beside the timer block
`timescale 1ns/10ps
`default_nettype none
module tmrocp_partner (
   // control from the bench
   input wire logic sys_clk_i,
   input wire logic trig_i,
   // pins of the block
   input wire logic [1:0] pin_i,
   input wire logic [1:0] oe_i,
   output logic cap_one_o,
   output logic cap_two_o,
   // measured pulse length in clocks
   output int high_len_o
);
   assign cap_one_o = trig_i;
   assign cap_two_o = trig_i;
   // load counts clocks while the driven pin is high
   always_ff @(posedge sys_clk_i) begin
      if (oe_i[0] && pin_i[0]) high_len_o <= high_len_o + 1;
      else if (!trig_i) high_len_o <= 0;
   end
endmodule // tmrocp_partner
`default_nettype wire

/* test_timer_output_compare_one_pulse.sv */
// self-checking bench of the timer compare and one-pulse block
`timescale 1ns/10ps
`default_nettype none
module test_timer_output_compare_one_pulse;
   logic sys_clk_i = 0, reset_i = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic rready = 0, mask = 0, trig = 0, awready, wready, bvalid, arready, rvalid, irq, c1, c2;
   logic [7:0] awaddr = 0, araddr = 0, d;
   logic [31:0] wdata = 0, rdata;
   logic [1:0] bresp, rresp, pin, oe, rr;
   int err_count = 0, n_checks = 0, len, seed = 13014, i;
   logic [7:0] mdl [int];
   initial forever #10 sys_clk_i = ~sys_clk_i;
   tmrocp_top dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .capture_input_one_i(c1), .capture_input_two_i(c2),
      .ext_clk_i(1'b0), .compare_output_pin_o(pin), .compare_output_pin_oe_o(oe),
      .global_irq_mask_i(mask), .timer_irq_o(irq));
   tmrocp_partner load (.sys_clk_i(sys_clk_i), .trig_i(trig), .pin_i(pin), .oe_i(oe),
      .cap_one_o(c1), .cap_two_o(c2), .high_len_o(len));
   task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s exp %h seen %h", s, exp, seen);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task tmo(input bit hit);
      if (hit) begin
         err_count++;
         tally_and_finish;
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      int n;
      @(posedge sys_clk_i);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, v, 3'h7};
      for (n = 0; n < 99 && !(bvalid && !awvalid && !wvalid); n++) begin
         @(posedge sys_clk_i);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end
      bready <= 0;
      tmo(n >= 99);
      chk("bresp", bresp, 0);
      mdl[a] = v;
   endtask
   task rd(input logic [7:0] a);
      int n;
      @(posedge sys_clk_i);
      {araddr, arvalid, rready} <= {a, 2'h3};
      for (n = 0; n < 99 && !(rvalid && !arvalid); n++) begin
         @(posedge sys_clk_i);
         if (arready) arvalid <= 0;
      end
      {d, rr} = {rdata[7:0], rresp};
      rready <= 0;
      tmo(n >= 99);
   endtask
   task rc(input logic [7:0] a);
      rd(a);
      chk($sformatf("reg %h", a), rdata, {24'h0, mdl[a]});
      chk("rresp", rr, tmrocp_pkg::RESP_OKAY);
   endtask
   task wt(input logic v);
      for (i = 0; i < 199 && pin[0] !== v; i++) @(posedge sys_clk_i);
      tmo(i >= 199);
   endtask
   initial begin
      for (i = 0; i < 4; i++) mdl[8'h0c + 4 * i] = i[0] ? 8'h00 : 8'h80;
      repeat (3) @(posedge sys_clk_i);
      chk("pins in reset", {pin, oe, irq}, 0);
      reset_i <= 0;
      repeat (3) @(posedge sys_clk_i);
      for (i = 0; i < 4; i++) rc(8'h0c + 4 * i);
      rd(8'h34);
      chk("unmapped resp", rr, tmrocp_pkg::RESP_SLVERR);
      d = 8'h80 | $random(seed);
      wr(tmrocp_pkg::ADDR_CMP2_HI, d);
      wr(tmrocp_pkg::ADDR_CMP2_LO, $random(seed));
      for (i = 0; i < 2; i++) rc(tmrocp_pkg::ADDR_CMP2_HI + 4 * i);
      wr(tmrocp_pkg::ADDR_CTL_ONE, 8'h12);
      wr(tmrocp_pkg::ADDR_CTL_TWO, 8'h01);
      wr(tmrocp_pkg::ADDR_CMP1_HI, 8'h00);
      rd(tmrocp_pkg::ADDR_FLAGS);
      wr(tmrocp_pkg::ADDR_CMP1_LO, 8'h10);
      wr(tmrocp_pkg::ADDR_CNT_LO, 8'h00);
      wt(1);
      chk("match time", i >= 34 && i <= 50, 1);
      chk("pin enables", oe, 2'h1);
      repeat (3) @(posedge sys_clk_i);
      chk("irq unmasked", irq, 1);
      mask <= 1;
      repeat (3) @(posedge sys_clk_i);
      chk("irq masked", irq, 0);
      mask <= 0;
      mdl[tmrocp_pkg::ADDR_FLAGS] = 8'h04;
      rc(tmrocp_pkg::ADDR_FLAGS);
      rc(tmrocp_pkg::ADDR_CMP1_LO);
      mdl[tmrocp_pkg::ADDR_FLAGS] = 8'h00;
      rc(tmrocp_pkg::ADDR_FLAGS);
      wr(tmrocp_pkg::ADDR_CTL_ONE, 8'h40);
      wt(0);
      rc(tmrocp_pkg::ADDR_FLAGS);
      wr(tmrocp_pkg::ADDR_CTL_TWO, 8'h05);
      wr(tmrocp_pkg::ADDR_CTL_ONE, 8'h74);
      repeat (6) @(posedge sys_clk_i);
      chk("force in one-pulse", pin[0], 0);
      wr(tmrocp_pkg::ADDR_CTL_ONE, 8'h25);
      trig <= 1;
      wt(1);
      wt(0);
      chk("pulse length", len >= 38 && len <= 46, 1);
      chk("capture irq", irq, 1);
      mdl[tmrocp_pkg::ADDR_FLAGS] = 8'h01;
      rc(tmrocp_pkg::ADDR_FLAGS);
      trig <= 0;
      wr(tmrocp_pkg::ADDR_CTL_TWO, 8'h20);
      wr(tmrocp_pkg::ADDR_CTL_ONE, 8'h26);
      wr(tmrocp_pkg::ADDR_CMP2_HI, 8'h00);
      rd(tmrocp_pkg::ADDR_FLAGS);
      wr(tmrocp_pkg::ADDR_CMP2_LO, 8'h04);
      wr(tmrocp_pkg::ADDR_CNT_LO, 8'h00);
      for (i = 0; i < 199 && irq !== 1; i++) @(posedge sys_clk_i);
      tmo(i >= 199);
      chk("divide by eight match", i >= 56 && i <= 68, 1);
      chk("pin two unused", {oe, pin[1]}, 0);
      mdl[tmrocp_pkg::ADDR_FLAGS] = 8'h0b;
      rc(tmrocp_pkg::ADDR_FLAGS);
      tally_and_finish;
   end
endmodule // test_timer_output_compare_one_pulse
`default_nettype wire
